//--- core/suspend_resume_power_control.sv
`timescale 1ns/10ps
`default_nettype none
module suspend_resume_power_control
  import power_seq_pkg::*;
#(
  parameter int unsigned PORTS    = N_PORTS,
  parameter int unsigned FILT_CYC = OC_FILT_CYC
) (
  // clock, reset, enable
  input  wire logic             ref_clk,
  input  wire logic             nrst,
  input  wire logic             clk_en,
  // reference for the functional clocks
  input  wire logic             ref_clock_input,
  // sleep/wake pin
  input  wire logic             sleep_wake_in,
  output logic                  sleep_wake_out,
  output logic                  sleep_wake_oe_n,
  // wake sources
  input  wire logic             connect_change,
  input  wire logic             chip_select_low,
  // software control
  input  wire logic             host_run,
  input  wire logic             suspend_req,
  input  wire logic [31:0]      power_down_ctrl,
  input  wire logic [31:0]      hw_mode_ctrl,
  input  wire logic             clocks_ready_clear,
  // status
  output logic                  suspended,
  output logic                  clocks_ready_irq,
  output logic [N_FUNC_CLK-1:0] func_clk_run,
  output logic [PDC_BLK_MSB:0]  block_enable,
  // port power
  input  wire logic [PORTS-1:0] port_power_req,
  input  wire logic [PORTS-1:0] overcurrent_input_low,
  input  wire logic [PORTS-1:0] analog_oc_trip,
  output logic [PORTS-1:0]      port_power_enable_low,
  output logic [PORTS-1:0]      oc_status
);

  localparam int unsigned CW = PDC_CLKOFF_MSB - PDC_CLKOFF_LSB + 1;

  typedef struct packed {
    pwr_state_type         state;
    logic [SLOW_W-1:0]     slow_cnt;
    logic                  slow_tick;
    logic [CW-1:0]         clkoff;
    wake_event_type        pend;
    logic                  lock_d;
    logic                  irq;
    logic [PDC_BLK_MSB:0]  blk_en;
    logic                  oe_n;
  } seq_state_type;

  seq_state_type  r;
  seq_state_type  n;
  wake_event_type ev;
  logic           locked;

  assign ev.connect_change = connect_change;
  assign ev.chip_select    = !chip_select_low;
  assign ev.wake_low       = !sleep_wake_in;

  always_comb begin
    n           = r;
    n.slow_tick = 1'b0;
    // always-on slow tick; the only timebase alive in suspend
    if (r.slow_cnt == SLOW_W'(SLOW_DIV - 1)) begin
      n.slow_cnt  = '0;
      n.slow_tick = 1'b1;
    end else begin
      n.slow_cnt = r.slow_cnt + SLOW_W'(1);
    end

    unique case (r.state)
      st_normal: begin
        n.pend = '0;
        if (suspend_req && !host_run) begin
          n.state = st_suspend;
        end
      end
      st_suspend: begin
        // connect and chip-select pulses are held so a tick between them cannot miss them
        n.pend.connect_change = r.pend.connect_change | ev.connect_change;
        n.pend.chip_select    = r.pend.chip_select | ev.chip_select;
        n.pend.wake_low       = ev.wake_low;
        // two samples low, so a one-cycle glitch on the pin cannot wake
        if (r.slow_tick && (r.pend.connect_change || r.pend.chip_select
                            || (r.pend.wake_low && ev.wake_low))) begin
          n.state  = st_resume;
          n.clkoff = power_down_ctrl[PDC_CLKOFF_MSB:PDC_CLKOFF_LSB];
          n.pend   = '0;
        end
      end
      st_resume: begin
        if (host_run) begin
          n.state = st_normal;
        end else if (r.slow_tick) begin
          // one slow tick per count: 16 bits reach well past 500 ms
          if (r.clkoff == '0) begin
            n.state = st_suspend;
          end else begin
            n.clkoff = r.clkoff - CW'(1);
          end
        end
      end
    endcase

    // set beats clear when both land together
    n.lock_d = locked;
    if (locked && !r.lock_d) begin
      n.irq = 1'b1;
    end else if (clocks_ready_clear) begin
      n.irq = 1'b0;
    end

    n.blk_en = locked ? ~power_down_ctrl[PDC_BLK_MSB:0] : '0;
    n.oe_n   = (n.state == st_suspend);
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      r        <= '0;
      r.state  <= st_normal;
      r.clkoff <= PDC_RESET[PDC_CLKOFF_MSB:PDC_CLKOFF_LSB];
    end else if (clk_en) begin
      r <= n;
    end
  end

  // main clocks stop in suspend and relock after wake, inside the irq budget
  func_clock_gate #(
    .N_CLK (N_FUNC_CLK)
  ) u_clk (
    .ref_clk         (ref_clk),
    .nrst            (nrst),
    .clk_en          (clk_en),
    .run             (r.state != st_suspend),
    .ref_clock_input (ref_clock_input),
    .locked          (locked),
    .func_clk_run    (func_clk_run)
  );

  port_oc_guard #(
    .PORTS    (PORTS),
    .FILT_CYC (FILT_CYC)
  ) u_oc (
    .ref_clk               (ref_clk),
    .nrst                  (nrst),
    .clk_en                (clk_en),
    .digital_mode          (hw_mode_ctrl[HWM_OC_DIG_BIT]),
    .power_req             (port_power_req),
    .overcurrent_input_low (overcurrent_input_low),
    .analog_oc_trip        (analog_oc_trip),
    .port_power_enable_low (port_power_enable_low),
    .oc_status             (oc_status)
  );

  // awake drives the line low; suspend leaves it to the pull-up
  assign sleep_wake_out   = 1'b0;
  assign sleep_wake_oe_n  = r.oe_n;
  // wake-to-suspend time is the slow window set by the clock-off count
  assign suspended        = (r.state == st_suspend);
  assign clocks_ready_irq = r.irq;
  assign block_enable     = r.blk_en;

endmodule
`default_nettype wire

//--- core/power_seq_pkg.sv
package power_seq_pkg;

  // timing base
  localparam int unsigned CLK_HZ         = 25_000_000;
  localparam int unsigned REF_HZ         = 12_000_000;
  localparam int unsigned SLOW_HZ        = 100_000;
  localparam int unsigned SLOW_DIV       = CLK_HZ / SLOW_HZ;
  localparam int unsigned SLOW_W         = $clog2(SLOW_DIV);

  // main clock restart after wake, counted in reference edges
  localparam int unsigned LOCK_US        = 50;
  localparam int unsigned LOCK_EDGES     = (REF_HZ / 1_000_000) * LOCK_US;
  localparam int unsigned LOCK_W         = $clog2(LOCK_EDGES + 1);

  // overcurrent filters
  localparam int unsigned OC_FILT_MS     = 10;
  localparam int unsigned OC_FILT_CYC    = (CLK_HZ / 1000) * OC_FILT_MS;
  localparam int unsigned AN_DEGLITCH_US = 1;
  localparam int unsigned AN_CYC         = (CLK_HZ / 1_000_000) * AN_DEGLITCH_US;

  // power-down control word layout and reset value
  localparam int unsigned PDC_CLKOFF_LSB = 16;
  localparam int unsigned PDC_CLKOFF_MSB = 31;
  localparam int unsigned PDC_BLK_MSB    = 15;
  localparam logic [31:0] PDC_RESET      = 32'h03e8_1ba0;

  // mode control word: this bit high selects the digital overcurrent scheme
  localparam int unsigned HWM_OC_DIG_BIT = 15;

  localparam int unsigned N_FUNC_CLK     = 3;
  localparam int unsigned N_PORTS        = 3;

  typedef enum logic [1:0] {st_normal, st_suspend, st_resume} pwr_state_type;

  typedef struct packed {
    logic connect_change;
    logic chip_select;
    logic wake_low;
  } wake_event_type;

endpackage

//--- core/func_clock_gate.sv
`timescale 1ns/10ps
`default_nettype none
module func_clock_gate
  import power_seq_pkg::*;
#(
  parameter int unsigned N_CLK = N_FUNC_CLK
) (
  // clock and reset
  input  wire logic             ref_clk,
  input  wire logic             nrst,
  input  wire logic             clk_en,
  // control
  input  wire logic             run,
  input  wire logic             ref_clock_input,
  // status
  output logic                  locked,
  output logic [N_CLK-1:0]      func_clk_run
);

  typedef struct packed {
    logic              ref_d;
    logic [LOCK_W-1:0] edges;
    logic              locked;
    logic [N_CLK-1:0]  clk_run;
  } gate_state_type;

  gate_state_type r;
  gate_state_type n;

  always_comb begin
    n       = r;
    n.ref_d = ref_clock_input;
    if (!run) begin
      // stopped clocks must relock from scratch
      n.edges  = '0;
      n.locked = 1'b0;
    end else if (!r.locked && ref_clock_input && !r.ref_d) begin
      if (r.edges == LOCK_W'(LOCK_EDGES - 1)) begin
        n.locked = 1'b1;
      end
      n.edges = r.edges + LOCK_W'(1);
    end
    for (int i = 0; i < N_CLK; i++) begin
      n.clk_run[i] = n.locked;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      r <= '0;
    end else if (clk_en) begin
      r <= n;
    end
  end

  assign locked       = r.locked;
  assign func_clk_run = r.clk_run;

endmodule
`default_nettype wire

//--- core/port_oc_guard.sv
`timescale 1ns/10ps
`default_nettype none
module port_oc_guard
  import power_seq_pkg::*;
#(
  parameter int unsigned PORTS    = N_PORTS,
  parameter int unsigned FILT_CYC = OC_FILT_CYC
) (
  // clock and reset
  input  wire logic             ref_clk,
  input  wire logic             nrst,
  input  wire logic             clk_en,
  // mode and requests
  input  wire logic             digital_mode,
  input  wire logic [PORTS-1:0] power_req,
  // switch side
  input  wire logic [PORTS-1:0] overcurrent_input_low,
  input  wire logic [PORTS-1:0] analog_oc_trip,
  output logic [PORTS-1:0]      port_power_enable_low,
  output logic [PORTS-1:0]      oc_status
);

  // wide enough for whichever filter is longer
  localparam int unsigned FW = $clog2(((FILT_CYC > AN_CYC) ? FILT_CYC : AN_CYC) + 1);

  typedef struct packed {
    logic [PORTS-1:0][FW-1:0] cnt;
    logic [PORTS-1:0]         trip;
    logic [PORTS-1:0]         pwr_low;
  } guard_state_type;

  guard_state_type r;
  guard_state_type n;

  always_comb begin
    logic          hit;
    logic [FW-1:0] lim;
    hit = 1'b0;
    lim = '0;
    n   = r;
    for (int p = 0; p < PORTS; p++) begin
      hit = digital_mode ? !overcurrent_input_low[p] : analog_oc_trip[p];
      // inrush shorter than the filter never trips the port
      lim = digital_mode ? FW'(FILT_CYC - 1) : FW'(AN_CYC - 1);
      if (!hit) begin
        n.cnt[p] = '0;
      end else if (r.cnt[p] >= lim) begin
        n.trip[p] = 1'b1;
      end else begin
        n.cnt[p] = r.cnt[p] + FW'(1);
      end
      // trip holds while requested; once the request drops it clears when the raw hit goes away
      if (!power_req[p] && !n.trip[p]) begin
        n.trip[p] = 1'b0;
      end else if (!power_req[p]) begin
        n.trip[p] = hit;
      end
      n.pwr_low[p] = !(power_req[p] && !n.trip[p]);
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      r         <= '0;
      r.pwr_low <= '1;
    end else if (clk_en) begin
      r <= n;
    end
  end

  assign port_power_enable_low = r.pwr_low;
  assign oc_status             = r.trip;

endmodule
`default_nettype wire

//--- tb/host_switch_model.sv
`timescale 1ns/10ps
`default_nettype none
module host_switch_model (
  // processor gpio
  input  wire logic       gpio_low,
  // device wake pin
  input  wire logic       pin_out,
  input  wire logic       pin_oe_n,
  output logic            pin_level,
  // port power switches
  input  wire logic [2:0] oc_cmd,
  input  wire logic [2:0] sw_en_low,
  output logic [2:0]      oc_low
);
  // pull-up holds the line high unless a party pulls it low
  assign pin_level = !(gpio_low || (!pin_oe_n && !pin_out));
  // an unpowered switch cannot report overcurrent
  assign oc_low = ~(oc_cmd & ~sw_en_low);
endmodule
`default_nettype wire

//--- tb/power_seq_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module power_seq_monitor
  import power_seq_pkg::*;
#(
  parameter int unsigned PORTS    = N_PORTS,
  parameter int unsigned FILT_CYC = OC_FILT_CYC
) (
  // clock and reset
  input wire logic                  ref_clk, nrst,
  // wake pin and control
  input wire logic                  sleep_wake_in, sleep_wake_out, sleep_wake_oe_n, host_run,
  input wire logic [31:0]           power_down_ctrl, hw_mode_ctrl,
  // status
  input wire logic                  suspended, clocks_ready_irq,
  input wire logic [N_FUNC_CLK-1:0] func_clk_run,
  input wire logic [PDC_BLK_MSB:0]  block_enable,
  // port power, port 0 stands for all
  input wire logic [PORTS-1:0]      port_power_req, overcurrent_input_low, analog_oc_trip,
  input wire logic [PORTS-1:0]      port_power_enable_low
);
  // wake-to-clocks budget: 100 us of ref_clk cycles
  localparam int unsigned RDY_CYC = CLK_HZ / 10_000;
  int unsigned dcnt;
  int unsigned acnt;
  int unsigned wcnt;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  // consecutive overcurrent samples, cleared by any gap
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      dcnt <= 0;
      acnt <= 0;
      wcnt <= 0;
    end else begin
      // awake with clocks still stopped; too long for a delay range
      wcnt <= (suspended || (&func_clk_run)) ? 0 : wcnt + 1;
      dcnt <= (hw_mode_ctrl[HWM_OC_DIG_BIT] && port_power_req[0] && !overcurrent_input_low[0])
              ? dcnt + 1 : 0;
      acnt <= (!hw_mode_ctrl[HWM_OC_DIG_BIT] && port_power_req[0] && analog_oc_trip[0])
              ? acnt + 1 : 0;
    end
  end
  a_line_state: assert property (sleep_wake_oe_n == suspended && !sleep_wake_out)
    else $error("wake pin drive differs from state");
  a_stop_clocks: assert property (suspended [*2] |-> func_clk_run == 3'b000)
    else $error("clocks run in suspend");
  a_wake_low: assert property (suspended && !sleep_wake_in |-> ##[1:252] !suspended)
    else $error("low wake line ignored");
  a_ready_soon: assert property (wcnt <= RDY_CYC)
    else $error("clocks late after wake");
  a_irq_on_lock: assert property ($rose(&func_clk_run) |=> clocks_ready_irq)
    else $error("no clocks ready flag");
  a_run_holds: assert property (host_run && !suspended |=> !suspended)
    else $error("suspend while running");
  a_blocks_follow: assert property ((&func_clk_run) [*3] |->
    block_enable == ~$past(power_down_ctrl[15:0]))
    else $error("block enables wrong");
  a_oc_digital: assert property (dcnt == FILT_CYC |-> port_power_enable_low[0])
    else $error("digital overcurrent not cut");
  a_oc_analog: assert property (acnt == AN_CYC |-> port_power_enable_low[0])
    else $error("analog overcurrent not cut");
  a_oc_filtered: assert property ($rose(port_power_enable_low[0]) && port_power_req[0]
    && $past(port_power_req[0]) && hw_mode_ctrl[HWM_OC_DIG_BIT] |-> dcnt >= FILT_CYC)
    else $error("overcurrent cut too early");
  cover property ($fell(suspended));
  cover property ($rose(port_power_enable_low[0]));
  cover property (host_run && $rose(clocks_ready_irq));
endmodule
bind suspend_resume_power_control power_seq_monitor #(.PORTS(PORTS), .FILT_CYC(FILT_CYC)) mon (
  .ref_clk, .nrst, .sleep_wake_in, .sleep_wake_out, .sleep_wake_oe_n, .host_run,
  .power_down_ctrl, .hw_mode_ctrl, .suspended, .clocks_ready_irq, .func_clk_run,
  .block_enable, .port_power_req, .overcurrent_input_low, .analog_oc_trip,
  .port_power_enable_low);
`default_nettype wire

//--- tb/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import power_seq_pkg::*;
  localparam int unsigned FC = 20;
  logic        ref_clk, nrst, ref_clock_input, sleep_wake_in, sleep_wake_out, sleep_wake_oe_n;
  logic        connect_change, chip_select_low, host_run, suspend_req, clocks_ready_clear;
  logic        suspended, clocks_ready_irq, gpio_low;
  logic [31:0] power_down_ctrl, hw_mode_ctrl;
  logic [2:0]  func_clk_run, port_power_req, overcurrent_input_low, analog_oc_trip;
  logic [2:0]  port_power_enable_low, oc_status, oc_cmd;
  logic [15:0] block_enable;
  int          n_errors, checks_done, seed, k, t, cnt;

  suspend_resume_power_control #(.FILT_CYC(FC)) dut (
    .ref_clk, .nrst, .clk_en(1'b1), .ref_clock_input, .sleep_wake_in, .sleep_wake_out,
    .sleep_wake_oe_n, .connect_change, .chip_select_low, .host_run, .suspend_req,
    .power_down_ctrl, .hw_mode_ctrl, .clocks_ready_clear, .suspended, .clocks_ready_irq,
    .func_clk_run, .block_enable, .port_power_req, .overcurrent_input_low, .analog_oc_trip,
    .port_power_enable_low, .oc_status);
  host_switch_model far (
    .gpio_low, .pin_out(sleep_wake_out), .pin_oe_n(sleep_wake_oe_n), .pin_level(sleep_wake_in),
    .oc_cmd, .sw_en_low(port_power_enable_low), .oc_low(overcurrent_input_low));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  function automatic logic pick(input int w);
    return (w == 0) ? suspended : (w == 1) ? clocks_ready_irq : port_power_enable_low[k];
  endfunction
  // bounded wait, cycles taken left in t
  task automatic wait_on(input int w, input logic v, input int lim);
    t = 0;
    while (pick(w) !== v && t < lim) begin
      @(posedge ref_clk);
      t++;
    end
  endtask
  function automatic logic in_rng(input int v, input int lo, input int hi);
    return v >= lo && v <= hi;
  endfunction
  task automatic go_sleep;
    suspend_req <= 1'b1;
    clocks_ready_clear <= 1'b1;
    @(posedge ref_clk);
    suspend_req <= 1'b0;
    clocks_ready_clear <= 1'b0;
    @(posedge ref_clk);
    chk({suspended, sleep_wake_oe_n, sleep_wake_in}, 3'b111);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  always #41.667 ref_clock_input = ~ref_clock_input;
  // about two and a half times the expected run length
  initial begin
    repeat (40000) @(posedge ref_clk);
    n_errors++;
    tally_and_finish;
  end

  initial begin
    seed = 32'h1d5f;
    {nrst, ref_clock_input, connect_change, host_run, suspend_req, clocks_ready_clear} = '0;
    {gpio_low, port_power_req, analog_oc_trip, oc_cmd, hw_mode_ctrl} = '0;
    chip_select_low = 1'b1;
    n_errors = 0;
    checks_done = 0;
    // short clock-off window keeps the run brief
    power_down_ctrl = {16'h0006, 16'($random(seed))};
    repeat (4) @(posedge ref_clk);
    nrst <= 1'b1;
    @(posedge ref_clk);
    chk({suspended, sleep_wake_oe_n, clocks_ready_irq, port_power_enable_low, oc_status},
        9'h038);
    wait_on(1, 1'b1, 2500);
    chk({clocks_ready_irq, func_clk_run}, 4'hf);
    repeat (3) @(posedge ref_clk);
    chk(block_enable ^ power_down_ctrl[15:0], 16'hffff);
    go_sleep;
    repeat (600) @(posedge ref_clk);
    chk({suspended, func_clk_run}, 4'h8);
    $display("test power_up_and_quiet_line done");
    for (int s = 0; s < 3; s++) begin
      if (s != 0)
        go_sleep;
      connect_change <= (s == 1);
      chip_select_low <= (s != 2);
      gpio_low <= (s == 0);
      @(posedge ref_clk);
      {connect_change, chip_select_low} <= 2'b01;
      wait_on(0, 1'b0, 260);
      gpio_low <= 1'b0;
      host_run <= 1'b1;
      chk(t < 260, 1'b1);
      wait_on(1, 1'b1, 2500);
      chk(clocks_ready_irq, 1'b1);
      repeat (2000) @(posedge ref_clk);
      chk(suspended, 1'b0);
      host_run <= 1'b0;
    end
    $display("test wake_sources done");
    cnt = 5 + ($random(seed) & 3);
    power_down_ctrl[31:16] <= 16'(cnt);
    go_sleep;
    gpio_low <= 1'b1;
    wait_on(0, 1'b0, 260);
    gpio_low <= 1'b0;
    wait_on(0, 1'b1, 3000);
    chk(in_rng(t, (cnt + 1) * 250 - 3, (cnt + 1) * 250 + 3), 1'b1);
    gpio_low <= 1'b1;
    host_run <= 1'b1;
    wait_on(0, 1'b0, 260);
    gpio_low <= 1'b0;
    $display("test resume_timeout done");
    hw_mode_ctrl <= 32'h0000_8000;
    port_power_req <= 3'b111;
    repeat (3) @(posedge ref_clk);
    chk(port_power_enable_low, 3'b000);
    for (k = 0; k < 3; k++) begin
      oc_cmd[k] <= 1'b1;
      repeat (FC - 1) @(posedge ref_clk);
      oc_cmd[k] <= 1'b0;
      repeat (4) @(posedge ref_clk);
      chk({oc_status[k], port_power_enable_low[k]}, 2'b00);
      oc_cmd[k] <= 1'b1;
      wait_on(2, 1'b1, 100);
      chk({oc_status[k], in_rng(t, FC, FC + 4)}, 2'b11);
    end
    {hw_mode_ctrl, port_power_req, oc_cmd} <= '0;
    repeat (3) @(posedge ref_clk);
    port_power_req <= 3'b111;
    oc_cmd[0] <= 1'b1;
    k = 0;
    repeat (60) @(posedge ref_clk);
    chk(port_power_enable_low[0], 1'b0);
    oc_cmd[0] <= 1'b0;
    analog_oc_trip[0] <= 1'b1;
    wait_on(2, 1'b1, 100);
    chk(in_rng(t, AN_CYC, AN_CYC + 4), 1'b1);
    $display("test overcurrent done");
    tally_and_finish;
  end
endmodule
`default_nettype wire
